// ===== include/vt_pkg.sv
/*
 * Constants for the vertical timing configuration block: register
 * offsets, field positions, reset values and counter start values.
 * Assumes a 32-bit APB master and a single 10 MHz clock.
 */
package vt_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_MARK_A = 8'h00;
	localparam logic [7:0] OFS_MARK_B = 8'h04;
	localparam logic [7:0] OFS_MARK_C = 8'h08;
	localparam logic [7:0] OFS_VSIZE  = 8'h0C;
	localparam logic [7:0] OFS_THA    = 8'h10;
	localparam logic [7:0] OFS_CTRL   = 8'h14;
	localparam logic [7:0] OFS_STAT   = 8'h18;

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam int POS_W  = 11;
	localparam int HI_LSB = 16;
	localparam int LO_LSB = 0;
	localparam int CTRL_INTERLACE_BIT = 0;
	localparam int CTRL_ENABLE_BIT    = 1;
	localparam int STAT_FIELD_BIT     = 15;
	localparam int STAT_HANC_BIT      = 14;
	localparam int N_MARK = 6;
	localparam int FIRST_GATED_MARK = 3;

	// ----------------------------------------------------------------
	// Write masks and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] PAIR_MASK  = 32'h07FF07FF;
	localparam logic [31:0] VSIZE_MASK = 32'h000007FF;
	localparam logic [31:0] CTRL_MASK  = 32'h07FF0003;
	localparam logic [31:0] REG_RESET  = 32'h00000000;

	// ----------------------------------------------------------------
	// Counter start values and pixel rate divider
	// ----------------------------------------------------------------
	localparam logic [10:0] LINE_FIRST = 11'h001;
	localparam logic [10:0] PIX_FIRST  = 11'h000;
	localparam logic [1:0]  DIV_RESET  = 2'h0;
	localparam logic [1:0]  DIV_LAST   = 2'h1;

endpackage : vt_pkg

// ===== src/vt_cnt.sv
/*
 * Position counter that steps on an enable pulse and reloads a start
 * value on restart or on wrap. Assumes step is a one-cycle pulse.
 */
`timescale 1ns/100ps
module vt_cnt #(
	parameter int W = 11
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// Control
	input  wire logic         step,
	input  wire logic         restart,
	input  wire logic         wrap,
	input  wire logic [W-1:0] first,
	// Count
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] cnt;
	} vt_cnt_st_t;

	vt_cnt_st_t st_reg;
	vt_cnt_st_t st_next;

	always_comb begin
		st_next = st_reg;
		if (restart || (step && wrap)) begin
			st_next.cnt = first;
		end else if (step) begin
			st_next.cnt = st_reg.cnt + {{(W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			// Counter rests on its start value, never below it
			st_reg.cnt <= first;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.cnt;

	property p_cnt_reload;
		@(posedge mclk) disable iff (rst)
		(restart || (step && wrap)) |=> (q == $past(first));
	endproperty
	a_cnt_reload: assert property (p_cnt_reload)
		else $error("counter did not reload its start value");

	property p_cnt_step;
		@(posedge mclk) disable iff (rst)
		(step && !wrap && !restart) |=> (q == $past(q) + 1'b1);
	endproperty
	a_cnt_step: assert property (p_cnt_step)
		else $error("counter did not advance by one");

endmodule : vt_cnt

// ===== src/vt_mark.sv
/*
 * One line-marker comparator: pulses when the line counter meets the
 * programmed marker at a line start, only while its gate is open.
 */
`timescale 1ns/100ps
module vt_mark (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Compare inputs
	input  wire logic [10:0] line,
	input  wire logic [10:0] marker,
	input  wire logic        gate,
	input  wire logic        strobe,
	// Result
	output logic             hit
);

	typedef struct packed {
		logic hit;
	} vt_mark_st_t;

	vt_mark_st_t st_reg;
	vt_mark_st_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.hit = strobe && gate && (line == marker);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign hit = st_reg.hit;

	property p_mark_gate;
		@(posedge mclk) disable iff (rst)
		(!gate || !strobe) |=> !hit;
	endproperty
	a_mark_gate: assert property (p_mark_gate)
		else $error("marker pulsed while gated off");

endmodule : vt_mark

// ===== src/vt_timing.sv
/*
 * Vertical timing configuration for one video output channel: an APB
 * register file of line markers, image size and ancillary start, with
 * the line and pixel counters that they steer.
 * Assumes an APB master on mclk; pixel rate is a divided enable.
 */
// Register access over APB and the register addresses were left to the implementer.
// What this block does
// - Vertical size writes act on the counters at once, no shadow.
// - Line counter starts at 1; positions compare against that count.
// - Fifth line marker is bits 26-16 of marker config B.
// - Seventh line marker, bottom-field boundary, is bits 10-0 of B.
// - Ninth line marker is bits 26-16 of marker config C.
// - Eleventh line marker is bits 10-0 of marker config C.
// - Seventh, ninth, eleventh markers act only with interlace set.
// - Vertical image size is bits 10-0, counted in frame lines.
// - Top ancillary insertion starts on line equal to bits 26-16.
// - Top ancillary insertion starts at pixel equal to bits 10-0.
// - Fields reset to zero, except the status line field, which resets to 1; reserved bits read zero, not writable.
// - First and third markers are bits 26-16 and 10-0 of config A.
`timescale 1ns/100ps
module vt_timing (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Timing outputs
	output logic      [10:0] line_count,
	output logic      [10:0] pixel_count,
	output logic             pixel_tick,
	output logic             field_bottom,
	output logic      [5:0]  marker_hit,
	output logic             hanc_start,
	output logic             hanc_active
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] mark_a;
		logic [31:0] mark_b;
		logic [31:0] mark_c;
		logic [31:0] vsize;
		logic [31:0] tha;
		logic [31:0] ctrl;
		logic [31:0] rdata;
		logic [1:0]  div;
		logic        tick;
		logic        field_bot;
		logic        hanc_start;
		logic        hanc_act;
	} vt_main_st_t;

	vt_main_st_t st_reg;
	vt_main_st_t st_next;

	logic              wr_en;
	logic              rd_setup;
	logic              mapped;
	logic              chan_on;
	logic              interlace_select;
	logic [10:0]       line_len;
	logic [10:0]       first_line_marker;
	logic [10:0]       third_line_marker;
	logic [10:0]       fifth_line_marker;
	logic [10:0]       seventh_line_marker;
	logic [10:0]       ninth_line_marker;
	logic [10:0]       eleventh_line_marker;
	logic [10:0]       frame_line_count;
	logic [10:0]       top_anc_vert_start;
	logic [10:0]       top_anc_horiz_start;
	logic [10:0]       pix_q;
	logic [10:0]       line_q;
	logic              pix_step;
	logic              pix_wrap;
	logic              line_wrap;
	logic              line_step;
	logic              line_start;
	logic              hanc_hit;
	logic [31:0]       stat_word;
	logic [5:0][10:0]  marks;

	// ----------------------------------------------------------------
	// Field extraction
	// ----------------------------------------------------------------
	// first and third
	assign first_line_marker =
		st_reg.mark_a[vt_pkg::HI_LSB +: vt_pkg::POS_W];
	assign third_line_marker =
		st_reg.mark_a[vt_pkg::LO_LSB +: vt_pkg::POS_W];
	assign fifth_line_marker =
		st_reg.mark_b[vt_pkg::HI_LSB +: vt_pkg::POS_W];
	assign seventh_line_marker =
		st_reg.mark_b[vt_pkg::LO_LSB +: vt_pkg::POS_W];
	assign ninth_line_marker =
		st_reg.mark_c[vt_pkg::HI_LSB +: vt_pkg::POS_W];
	assign eleventh_line_marker =
		st_reg.mark_c[vt_pkg::LO_LSB +: vt_pkg::POS_W];
	assign frame_line_count =
		st_reg.vsize[vt_pkg::LO_LSB +: vt_pkg::POS_W];
	assign top_anc_vert_start =
		st_reg.tha[vt_pkg::HI_LSB +: vt_pkg::POS_W];
	assign top_anc_horiz_start =
		st_reg.tha[vt_pkg::LO_LSB +: vt_pkg::POS_W];
	assign interlace_select = st_reg.ctrl[vt_pkg::CTRL_INTERLACE_BIT];
	assign chan_on = st_reg.ctrl[vt_pkg::CTRL_ENABLE_BIT];
	assign line_len = st_reg.ctrl[vt_pkg::HI_LSB +: vt_pkg::POS_W];

	assign marks[0] = first_line_marker;
	assign marks[1] = third_line_marker;
	assign marks[2] = fifth_line_marker;
	assign marks[3] = seventh_line_marker;
	assign marks[4] = ninth_line_marker;
	assign marks[5] = eleventh_line_marker;

	// ----------------------------------------------------------------
	// Counters
	// ----------------------------------------------------------------
	assign pix_step = st_reg.tick && chan_on;
	assign pix_wrap = (pix_q == line_len);
	// compares live size, no shadow copy
	assign line_wrap = (line_q >= frame_line_count);
	assign line_step = pix_step && pix_wrap;
	assign line_start = pix_step && (pix_q == vt_pkg::PIX_FIRST);

	vt_cnt #(
		.W (11)
	) u_pix (
		.mclk    (mclk),
		.rst     (rst),
		.step    (pix_step),
		.restart (!chan_on),
		.wrap    (pix_wrap),
		.first   (vt_pkg::PIX_FIRST),
		.q       (pix_q)
	);

	vt_cnt #(
		.W (11)
	) u_line (
		.mclk    (mclk),
		.rst     (rst),
		.step    (line_step),
		.restart (!chan_on),
		.wrap    (line_wrap),
		.first   (vt_pkg::LINE_FIRST),
		.q       (line_q)
	);

	// ----------------------------------------------------------------
	// Line markers
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < vt_pkg::N_MARK; gi++) begin : g_mark
			vt_mark u_mark (
				.mclk   (mclk),
				.rst    (rst),
				.line   (line_q),
				.marker (marks[gi]),
				.gate   ((gi < vt_pkg::FIRST_GATED_MARK) ||
					interlace_select),
				.strobe (line_start),
				.hit    (marker_hit[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	assign wr_en = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;

	always_comb begin
		if (paddr == vt_pkg::OFS_MARK_A) begin
			mapped = 1'b1;
		end else if (paddr == vt_pkg::OFS_MARK_B) begin
			mapped = 1'b1;
		end else if (paddr == vt_pkg::OFS_MARK_C) begin
			mapped = 1'b1;
		end else if (paddr == vt_pkg::OFS_VSIZE) begin
			mapped = 1'b1;
		end else if (paddr == vt_pkg::OFS_THA) begin
			mapped = 1'b1;
		end else if (paddr == vt_pkg::OFS_CTRL) begin
			mapped = 1'b1;
		end else if (paddr == vt_pkg::OFS_STAT) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end

	// Zero wait states: read data is captured in the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	always_comb begin
		stat_word = '0;
		stat_word[vt_pkg::HI_LSB +: vt_pkg::POS_W] = line_q;
		stat_word[vt_pkg::LO_LSB +: vt_pkg::POS_W] = pix_q;
		stat_word[vt_pkg::STAT_FIELD_BIT] = st_reg.field_bot;
		stat_word[vt_pkg::STAT_HANC_BIT] = st_reg.hanc_act;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;

		// Pixel-rate enable from the divider
		if (st_reg.div == vt_pkg::DIV_LAST) begin
			st_next.div = vt_pkg::DIV_RESET;
		end else begin
			st_next.div = st_reg.div + 2'h1;
		end
		st_next.tick = (st_reg.div == vt_pkg::DIV_LAST);

		if (wr_en) begin
			if (paddr == vt_pkg::OFS_MARK_A) begin
				st_next.mark_a = pwdata & vt_pkg::PAIR_MASK;
			end else if (paddr == vt_pkg::OFS_MARK_B) begin
				st_next.mark_b = pwdata & vt_pkg::PAIR_MASK;
			end else if (paddr == vt_pkg::OFS_MARK_C) begin
				st_next.mark_c = pwdata & vt_pkg::PAIR_MASK;
			end else if (paddr == vt_pkg::OFS_VSIZE) begin
				st_next.vsize = pwdata & vt_pkg::VSIZE_MASK;
			end else if (paddr == vt_pkg::OFS_THA) begin
				st_next.tha = pwdata & vt_pkg::PAIR_MASK;
			end else if (paddr == vt_pkg::OFS_CTRL) begin
				st_next.ctrl = pwdata & vt_pkg::CTRL_MASK;
			end
		end

		// Read data latched in setup, stable through access
		if (rd_setup) begin
			if (paddr == vt_pkg::OFS_MARK_A) begin
				st_next.rdata = st_reg.mark_a;
			end else if (paddr == vt_pkg::OFS_MARK_B) begin
				st_next.rdata = st_reg.mark_b;
			end else if (paddr == vt_pkg::OFS_MARK_C) begin
				st_next.rdata = st_reg.mark_c;
			end else if (paddr == vt_pkg::OFS_VSIZE) begin
				st_next.rdata = st_reg.vsize;
			end else if (paddr == vt_pkg::OFS_THA) begin
				st_next.rdata = st_reg.tha;
			end else if (paddr == vt_pkg::OFS_CTRL) begin
				st_next.rdata = st_reg.ctrl;
			end else if (paddr == vt_pkg::OFS_STAT) begin
				st_next.rdata = stat_word;
			end else begin
				st_next.rdata = vt_pkg::REG_RESET;
			end
		end

		st_next.field_bot = chan_on && interlace_select &&
			(seventh_line_marker != vt_pkg::PIX_FIRST) &&
			(line_q >= seventh_line_marker);

		st_next.hanc_start = hanc_hit;
		if (hanc_hit) begin
			st_next.hanc_act = 1'b1;
		end else if (!chan_on || line_step) begin
			st_next.hanc_act = 1'b0;
		end
	end

	assign hanc_hit = pix_step && !st_reg.field_bot &&
		(line_q == top_anc_vert_start) &&
		(pix_q == top_anc_horiz_start);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.rdata;
	assign line_count = line_q;
	assign pixel_count = pix_q;
	assign pixel_tick = st_reg.tick;
	assign field_bottom = st_reg.field_bot;
	assign hanc_start = st_reg.hanc_start;
	assign hanc_active = st_reg.hanc_act;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence s_wr(logic [7:0] a);
		psel && penable && pwrite && (paddr == a);
	endsequence

	property p_size_now;
		line_step && line_wrap |=> (line_count == 11'h001);
	endproperty
	a_size_now: assert property (p_size_now)
		else $error("line counter did not wrap to one at frame end");

	property p_fifth;
		s_wr(vt_pkg::OFS_MARK_B) |=>
			(fifth_line_marker == $past(pwdata[26:16])) &&
			(seventh_line_marker == $past(pwdata[10:0]));
	endproperty
	a_fifth: assert property (p_fifth)
		else $error("marker config B fields not stored");

	property p_ninth;
		s_wr(vt_pkg::OFS_MARK_C) |=>
			(ninth_line_marker == $past(pwdata[26:16])) &&
			(eleventh_line_marker == $past(pwdata[10:0]));
	endproperty
	a_ninth: assert property (p_ninth)
		else $error("marker config C fields not stored");

	property p_vsize;
		s_wr(vt_pkg::OFS_VSIZE) |=>
			(frame_line_count == $past(pwdata[10:0]));
	endproperty
	a_vsize: assert property (p_vsize)
		else $error("vertical size not stored in bits 10-0");

	property p_no_field;
		!interlace_select |=> !field_bottom;
	endproperty
	a_no_field: assert property (p_no_field)
		else $error("bottom field reported in progressive mode");

	property p_hanc;
		hanc_hit |=> hanc_start && hanc_active ##1 !hanc_start;
	endproperty
	a_hanc: assert property (p_hanc)
		else $error("ancillary insertion did not start on match");

	property p_hanc_pos;
		hanc_start |-> (pixel_count == top_anc_horiz_start + 11'h001) ||
			(pixel_count == vt_pkg::PIX_FIRST);
	endproperty
	a_hanc_pos: assert property (p_hanc_pos)
		else $error("ancillary start at wrong pixel");

	property p_rsv;
		psel && penable && !pwrite |->
			(prdata[31:27] == 5'h00);
	endproperty
	a_rsv: assert property (p_rsv)
		else $error("reserved bits read non-zero");

	property p_pix_clear;
		line_step |=> (pixel_count == 11'h000);
	endproperty
	a_pix_clear: assert property (p_pix_clear)
		else $error("pixel counter not cleared at line start");

endmodule : vt_timing

// ===== verif/vt_sink.sv
/*
 * Video encoder stand-in: counts the marker and ancillary start pulses
 * that it receives. Assumes pulses last one mclk cycle each.
 */
`timescale 1ns/100ps
module vt_sink (
	// Clock and control
	input  wire logic       mclk,
	input  wire logic       clr,
	// Stream markers
	input  wire logic [5:0] marker_hit,
	input  wire logic       hanc_start,
	// Counts
	output logic [5:0][31:0] hit_n,
	output int              hanc_n
);
	always @(posedge mclk) begin
		for (int i = 0; i < 6; i++) begin
			if (clr)
				hit_n[i] <= 0;
			else if (marker_hit[i] === 1'b1)
				hit_n[i] <= hit_n[i] + 1;
		end
		if (clr)
			hanc_n <= 0;
		else if (hanc_start === 1'b1)
			hanc_n <= hanc_n + 1;
	end
endmodule : vt_sink

// ===== verif/tb.sv
/*
 * Testbench for vt_timing: APB register checks and a line/pixel model
 * compared at every cycle. Assumes zero-wait APB and pixel rate mclk/2.
 */
`timescale 1ns/100ps
module tb;
	logic        mclk, rst, psel, penable, pwrite, pixel_tick;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic        pready, pslverr, err, field_bottom, hanc_start;
	logic        hanc_active, clr;
	logic [10:0] line_count, pixel_count;
	logic [5:0]  marker_hit;
	int          failures, total_checks, cycles, hanc_n;
	logic [5:0][31:0] hit_n;
	int          ml, mp, vs_sw, vs_q, il, vps, exp_hanc, exp_hit [6];
	bit          en_sw, en_q, track, prev_tick, ha;
	int          mk [6] = '{2, 4, 5, 4, 6, 3};
	localparam int LEN = 9;
	localparam int HPS = 8;

	vt_timing u_dut (.mclk(mclk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .line_count(line_count),
		.pixel_count(pixel_count), .pixel_tick(pixel_tick),
		.field_bottom(field_bottom), .marker_hit(marker_hit),
		.hanc_start(hanc_start), .hanc_active(hanc_active));
	vt_sink u_sink (.mclk(mclk), .clr(clr), .marker_hit(marker_hit),
		.hanc_start(hanc_start), .hit_n(hit_n), .hanc_n(hanc_n));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task conclude;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	task chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	// Request held until pready is seen high at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		// Only the bench timeout ends a wait
		while (pready !== 1'b1) begin
			@(posedge mclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		chk(err, 0, "pslverr on write");
	endtask : wr

	// ----------------------------------------------------------------
	// Line and pixel model
	// ----------------------------------------------------------------
	always @(negedge mclk) begin
		if (track) begin
			if (!en_q) begin
				ml = 1;
				mp = 0;
				ha = 0;
			end else if (prev_tick) begin
				// Pulses fire on the step that leaves the matching spot
				for (int i = 0; i < 6; i++)
					if (mp == 0 && ml == mk[i] && (i < 3 || il != 0))
						exp_hit[i]++;
				if (mp == LEN)
					ha = 0;
				if (!(il != 0 && ml >= mk[3]) && ml == vps &&
					mp == HPS) begin
					exp_hanc++;
					ha = 1;
				end
				if (mp == LEN) begin
					mp = 0;
					ml = (ml >= vs_q) ? 1 : ml + 1;
				end else
					mp++;
			end
			chk(line_count, ml, "line");
			chk(pixel_count, mp, "pixel");
			chk(hanc_active, ha, "hanc active");
			if (en_q && mp >= 2)
				chk(field_bottom, il != 0 && ml >= mk[3], "field");
		end
		prev_tick = pixel_tick;
		en_q = en_sw;
		vs_q = vs_sw;
	end

	// ----------------------------------------------------------------
	// Timing run: markers, ancillary start, optional size change
	// ----------------------------------------------------------------
	task run(input int il_v, input int vps_v, input int new_vs);
		il = il_v;
		vps = vps_v;
		vs_sw = 6;
		wr(vt_pkg::OFS_MARK_A, (mk[0] << 16) | mk[1]);
		wr(vt_pkg::OFS_MARK_B, (mk[2] << 16) | mk[3]);
		wr(vt_pkg::OFS_MARK_C, (mk[4] << 16) | mk[5]);
		wr(vt_pkg::OFS_VSIZE, vs_sw);
		// horizontal start kept a multiple of 8
		wr(vt_pkg::OFS_THA, (vps << 16) | HPS);
		exp_hit = '{0, 0, 0, 0, 0, 0};
		exp_hanc = 0;
		clr <= 1'b1;
		track = 1;
		wr(vt_pkg::OFS_CTRL, (LEN << 16) | 2 | il);
		en_sw = 1;
		clr <= 1'b0;
		repeat (250) @(posedge mclk);
		if (new_vs != 0) begin
			wr(vt_pkg::OFS_VSIZE, new_vs);
			vs_sw = new_vs;
		end
		repeat (250) @(posedge mclk);
		wr(vt_pkg::OFS_CTRL, 0);
		en_sw = 0;
		repeat (10) @(posedge mclk);
		track = 0;
		for (int i = 0; i < 6; i++)
			chk(hit_n[i], exp_hit[i], "marker count");
		chk(hanc_n, exp_hanc, "hanc count");
	endtask : run

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("[FAIL] %0t run did not finish", $time);
			conclude();
		end
	end

	initial begin
		logic [7:0]  ofs [6];
		logic [31:0] msk [6];
		ofs = '{vt_pkg::OFS_MARK_A, vt_pkg::OFS_MARK_B, vt_pkg::OFS_MARK_C,
			vt_pkg::OFS_VSIZE, vt_pkg::OFS_THA, vt_pkg::OFS_CTRL};
		msk = '{vt_pkg::PAIR_MASK, vt_pkg::PAIR_MASK, vt_pkg::PAIR_MASK,
			vt_pkg::VSIZE_MASK, vt_pkg::PAIR_MASK, vt_pkg::CTRL_MASK};
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		clr = 1'b1;
		seed = 32'h627AA2D5;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, ofs[i], 32'h0);
			chk(rd, vt_pkg::REG_RESET, "reset value");
			wr(ofs[i], 32'hFFFFFFFF);
			apb(1'b0, ofs[i], 32'h0);
			chk(rd, msk[i], "reserved bits");
			seed = xs(seed);
			wr(ofs[i], seed);
			apb(1'b0, ofs[i], 32'h0);
			chk(rd, seed & msk[i], "random data");
		end
		wr(vt_pkg::OFS_CTRL, 32'h0);
		wr(vt_pkg::OFS_STAT, 32'hFFFFFFFF);
		apb(1'b0, vt_pkg::OFS_STAT, 32'h0);
		chk(rd, 32'h00010000, "status idle");
		apb(1'b1, 8'h1C, 32'hFFFFFFFF);
		chk(err, 1, "unmapped write");
		apb(1'b0, 8'h1C, 32'h0);
		chk(err, 1, "unmapped read error");
		chk(rd, 32'h00000000, "unmapped read data");
		run(0, 3, 0);
		run(1, 3, 0);
		run(1, 5, 0);
		run(0, 3, 3);
		conclude();
	end
endmodule : tb
